// [common/alu_if.sv]
// operand and flag bundle between the status core and its alu
`timescale 1ns/1ns
interface alu_if;
   status_pkg::alu_op_e op;
   logic [status_pkg::DATA_W-1:0] a;
   logic [status_pkg::DATA_W-1:0] b;
   logic cin;
   logic [status_pkg::DATA_W-1:0] result;
   logic z;
   logic dc;
   logic c;
   logic aff_z;
   logic aff_dc;
   logic aff_c;
   modport core (output op, a, b, cin,
                 input result, z, dc, c, aff_z, aff_dc, aff_c);
   modport alu (input op, a, b, cin,
                output result, z, dc, c, aff_z, aff_dc, aff_c);
endinterface : alu_if

// [common/status_pkg.sv]
// constants, types and decoders shared by the status flag block
// Summary of operation
// - The status register answers at four mirror indices, one per bank.
// - In subtraction carry and nibble carry mean "no borrow" when set.
// - Subtraction adds the two's complement of the subtrahend.
// - Rotates through carry load carry with the bit shifted out.
// - Reset clears the bank bits, sets both reset-cause flags.
// - A flag-updating result aimed at status loses to the flag update.
// - Writes never reach the two reset-cause flags.
package status_pkg;
   localparam int ADDR_W = 12;
   localparam int AXI_DW = 32;
   localparam int DATA_W = 8;
   localparam int IDX_W = 10;
   localparam int IDX_LSB = 2;
   // register indices; byte address is index times four
   localparam logic [IDX_W-1:0] STATUS_IDX_B0 = 10'h003;
   localparam logic [IDX_W-1:0] STATUS_IDX_B1 = 10'h083;
   localparam logic [IDX_W-1:0] STATUS_IDX_B2 = 10'h103;
   localparam logic [IDX_W-1:0] STATUS_IDX_B3 = 10'h183;
   localparam logic [IDX_W-1:0] CMD_IDX = 10'h004;
   localparam logic [IDX_W-1:0] RESULT_IDX = 10'h005;
   localparam logic [IDX_W-1:0] XLATE_IDX = 10'h006;
   // status bit positions
   localparam int IND_BANK_BIT = 7;
   localparam int DBANK_HI_BIT = 6;
   localparam int DBANK_LO_BIT = 5;
   localparam int EXPIRY_BIT = 4;
   localparam int SLEEP_BIT = 3;
   localparam int Z_BIT = 2;
   localparam int DC_BIT = 1;
   localparam int C_BIT = 0;
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
   localparam logic [DATA_W-1:0] STATUS_WR_MASK = 8'hE7;
   // command word layout
   localparam int CMD_A_LSB = 0;
   localparam int CMD_B_LSB = 8;
   localparam int CMD_OP_LSB = 16;
   localparam int CMD_OP_W = 4;
   localparam int CMD_DEST_BIT = 24;
   localparam logic [3:0] STRB_ALL = 4'hF;
   // address translation layout
   localparam int DIR_OFS_W = 7;
   localparam int XL_MODE_BIT = 8;
   localparam int BANK_ADDR_W = 9;
   localparam int NIB_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
      OP_XOR = 4'h4, OP_ROR = 4'h5, OP_ROL = 4'h6, OP_CLR = 4'h7,
      OP_MOV = 4'h8, OP_SWAP = 4'h9, OP_COM = 4'hA, OP_INC = 4'hB,
      OP_DEC = 4'hC
   } alu_op_e;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0, SEL_STATUS = 3'h1, SEL_CMD = 3'h2,
      SEL_RESULT = 3'h3, SEL_XLATE = 3'h4
   } reg_sel_e;

   // shared by the read and write paths
   function automatic reg_sel_e reg_decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      idx = addr[ADDR_W-1:IDX_LSB];
      if (idx == STATUS_IDX_B0 || idx == STATUS_IDX_B1 ||
          idx == STATUS_IDX_B2 || idx == STATUS_IDX_B3) begin
         return SEL_STATUS;
      end
      else if (idx == CMD_IDX) begin
         return SEL_CMD;
      end
      else if (idx == RESULT_IDX) begin
         return SEL_RESULT;
      end
      else if (idx == XLATE_IDX) begin
         return SEL_XLATE;
      end
      return SEL_NONE;
   endfunction : reg_decode
endpackage : status_pkg

// [verif/cpu_status_flags_tb.sv]
// self-checking bench for the status flag block over its axi4-lite port
`timescale 1ns/1ns
module cpu_status_flags_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, indirect_bank;
   logic wdt_expired, sleep_exec, wdt_clear;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, direct_bank;
   logic [7:0] status_flags, st, v;
   int err_count, n_checks, i;
   logic [11:0] mirror [4] = '{12'h00C, 12'h20C, 12'h40C, 12'h60C};

   cpu_status_flags cpu_status_flags_inst (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .wdt_expired, .sleep_exec, .wdt_clear,
      .direct_bank, .indirect_bank, .status_flags);

   // free-running 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   // a bounded wait ran out: count it and stop
   task automatic time_out();
      err_count++;
      give_verdict();
   endtask : time_out

   // one axi write; address and data offered together, bready maybe late
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int n;
      logic slow;
      slow = 1'($urandom);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !slow;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            bready <= 1'b0;
            check({30'h0, bresp}, {30'h0, er});
            return;
         end
         // a late bready makes the response wait with bvalid held
         if (n == 2) bready <= 1'b1;
      end
      time_out();
   endtask : wr

   // one axi read compared with the expected word and response
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rready <= 1'b0;
            check(rdata, exp);
            check({30'h0, rresp}, {30'h0, er});
            return;
         end
      end
      time_out();
   endtask : rd_chk

   // reference alu: returns {affected z/dc/c, result, z, dc, c}
   function automatic logic [13:0] alu_m(input logic [3:0] op,
      input logic [7:0] f, input logic [7:0] w, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r, wv;
      logic [2:0] m;
      logic c, k;
      k = (op == 4'h1);
      wv = k ? ~w : w;
      s = {1'b0, f} + {1'b0, wv} + {8'h00, k};
      h = {1'b0, f[3:0]} + {1'b0, wv[3:0]} + {4'h0, k};
      m = 3'b100;
      c = ci;
      r = f;
      case (op)
         4'h0, 4'h1: begin
            r = s[7:0];
            m = 3'b111;
            c = s[8];
         end
         4'h2: r = f & w;
         4'h3: r = f | w;
         4'h4: r = f ^ w;
         4'h5: begin
            r = {ci, f[7:1]};
            m = 3'b001;
            c = f[0];
         end
         4'h6: begin
            r = {f[6:0], ci};
            m = 3'b001;
            c = f[7];
         end
         4'h7: r = 8'h00;
         4'h8: begin
            r = w;
            m = 3'b000;
         end
         4'h9: begin
            r = {f[3:0], f[7:4]};
            m = 3'b000;
         end
         4'hA: r = ~f;
         4'hB: r = f + 8'h01;
         4'hC: r = f - 8'h01;
         default: begin
            r = f;
            m = 3'b000;
         end
      endcase
      return {m, r, (r == 8'h00), h[4], c};
   endfunction : alu_m

   // command, then result and status read back against the model
   task automatic do_cmd(input logic [3:0] op, input logic [7:0] f,
                         input logic [7:0] w, input logic dst);
      logic [13:0] e;
      logic [7:0] n;
      if (dst) f = st;
      e = alu_m(op, f, w, st[0]);
      n = dst ? {e[10:8], st[4:3], e[5:3]} : st;
      st = {n[7:3], (e[13:11] & e[2:0]) | (~e[13:11] & n[2:0])};
      wr(12'h010, {7'h00, dst, 4'h0, op, f, w}, 4'hF, 2'h0);
      rd_chk(12'h014, {24'h0, e[10:3]}, 2'h0);
      rd_chk(12'h00C, {24'h0, st}, 2'h0);
   endtask : do_cmd

   // one-cycle event pulse {expiry, sleep, clear}, then the live byte
   task automatic ev(input logic [2:0] p);
      @(posedge aclk);
      {wdt_expired, sleep_exec, wdt_clear} <= p;
      @(posedge aclk);
      {wdt_expired, sleep_exec, wdt_clear} <= 3'b000;
      @(posedge aclk);
      #1;
      // priority: expiry over sleep over clear
      if (p[0]) st[4:3] = 2'b11;
      if (p[1]) st[4:3] = 2'b10;
      if (p[2]) st[4] = 1'b0;
      check({24'h0, status_flags}, {24'h0, st});
   endtask : ev

   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {wdt_expired, sleep_exec, wdt_clear} = 3'b000;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      wstrb = 4'h0;
      err_count = 0;
      n_checks = 0;
      i = $urandom(32'h3FB8);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      st = 8'h18;
      check({24'h0, status_flags}, 32'h18);
      rd_chk(12'h00C, 32'h18, 2'h0);
      $display("reset test done");
      ev(3'b010);
      ev(3'b100);
      ev(3'b001);
      ev(3'b010);
      ev(3'b011);
      ev(3'b110);
      $display("event test done");
      // writes through one mirror, read through the next
      for (i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hFF : 8'($urandom);
         wr(mirror[i % 4], {24'h0, v}, 4'h1, 2'h0);
         st = (v & 8'hE7) | (st & 8'h18);
         rd_chk(mirror[(i + 1) % 4], {24'h0, st}, 2'h0);
         check({29'h0, indirect_bank, direct_bank},
            {29'h0, st[7:5]});
      end
      $display("mirror test done");
      wr(12'h100, 32'hFFFF_FFFF, 4'hF, 2'h2);
      rd_chk(12'h100, 32'h0, 2'h2);
      rd_chk(12'h00C, {24'h0, st}, 2'h0);
      $display("unmapped test done");
      // corner cases: equal, borrow, overflow, nibble carry, rotates, clear
      do_cmd(4'h1, 8'h05, 8'h05, 1'b0);
      do_cmd(4'h1, 8'h00, 8'h01, 1'b0);
      do_cmd(4'h1, 8'h10, 8'h01, 1'b0);
      do_cmd(4'h0, 8'hFF, 8'h01, 1'b0);
      do_cmd(4'h0, 8'h0F, 8'h01, 1'b0);
      do_cmd(4'h5, 8'h01, 8'h00, 1'b0);
      do_cmd(4'h6, 8'h80, 8'h00, 1'b0);
      do_cmd(4'h7, 8'h00, 8'h00, 1'b1);
      do_cmd(4'h0, 8'h00, 8'hF0, 1'b1);
      do_cmd(4'hE, 8'h5A, 8'h00, 1'b0);
      // a partial-strobe command must leave result and status alone
      wr(12'h010, 32'h0000_0100, 4'h7, 2'h0);
      rd_chk(12'h014, 32'h5A, 2'h0);
      rd_chk(12'h00C, {24'h0, st}, 2'h0);
      rd_chk(12'h010, 32'h0, 2'h0);
      for (i = 0; i < 60; i++) begin
         do_cmd(4'($urandom_range(12, 0)), 8'($urandom), 8'($urandom),
            1'($urandom));
      end
      $display("alu test done");
      // bank bits drive the address translation
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         wr(12'h018, {23'h0, i[0], v}, 4'h3, 2'h0);
         rd_chk(12'h018, i[0] ? {23'h0, st[7], v} :
            {23'h0, st[6:5], v[6:0]}, 2'h0);
         do_cmd(4'h8, 8'h00, 8'($urandom), 1'b1);
      end
      $display("translate test done");
      give_verdict();
   end
endmodule : cpu_status_flags_tb

// [verilog/cpu_status_flags.sv]
// status register core with alu, reset-cause flags and an axi4-lite slave
`timescale 1ns/1ns
module cpu_status_flags (
   input wire logic aclk, // 100 MHz clock
   input wire logic aresetn, // synchronous reset, low
   input wire logic [status_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [status_pkg::AXI_DW-1:0] wdata, // write data
   input wire logic [3:0] wstrb, // write byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [status_pkg::ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [status_pkg::AXI_DW-1:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic wdt_expired, // watchdog timed out, pulse
   input wire logic sleep_exec, // sleep executed, pulse
   input wire logic wdt_clear, // watchdog cleared, pulse
   output logic [1:0] direct_bank, // direct addressing bank
   output logic indirect_bank, // indirect addressing half
   output logic [status_pkg::DATA_W-1:0] status_flags // live status byte
);
   // write channel state
   logic aw_full_q, aw_full_d;
   logic w_full_q, w_full_d;
   logic [status_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [status_pkg::AXI_DW-1:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic do_wr;
   status_pkg::reg_sel_e wsel;

   // read channel state
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [status_pkg::AXI_DW-1:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic ar_hs;
   status_pkg::reg_sel_e rsel;

   // core state
   logic [status_pkg::DATA_W-1:0] status_q, status_d;
   logic [status_pkg::DATA_W-1:0] result_q, result_d;
   logic [status_pkg::DATA_W-1:0] xl_ofs_q, xl_ofs_d;
   logic xl_ind_q, xl_ind_d;
   logic exec;
   logic dest_st;
   logic [status_pkg::DATA_W-1:0] merged;
   logic [status_pkg::BANK_ADDR_W-1:0] bank_addr;

   alu_if alu ();

   status_alu u_alu (
      .port (alu.alu)
   );

   // outputs come straight from the registers
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign status_flags = status_q;
   assign direct_bank =
      status_q[status_pkg::DBANK_HI_BIT:status_pkg::DBANK_LO_BIT];
   assign indirect_bank = status_q[status_pkg::IND_BANK_BIT];

   // address and data are held independently, so either may come first
   always_comb begin
      do_wr = aw_full_q && w_full_q && !bvalid_q;
      wsel = status_pkg::reg_decode(awaddr_q);
      aw_full_d = aw_full_q;
      awaddr_d = awaddr_q;
      w_full_d = w_full_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (awvalid && awready_q) begin
         aw_full_d = 1'b1;
         awaddr_d = awaddr;
      end
      if (wvalid && wready_q) begin
         w_full_d = 1'b1;
         wdata_d = wdata;
         wstrb_d = wstrb;
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (do_wr) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wsel == status_pkg::SEL_NONE) ?
                   status_pkg::RESP_SLVERR : status_pkg::RESP_OKAY;
      end
      awready_d = !aw_full_d;
      wready_d = !w_full_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= status_pkg::RESP_OKAY;
      end
      else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // status, alu execution and the bank translator
   always_comb begin
      // a partial-strobe command is ignored rather than half executed
      exec = do_wr && (wsel == status_pkg::SEL_CMD) &&
             (wstrb_q == status_pkg::STRB_ALL);
      dest_st = wdata_q[status_pkg::CMD_DEST_BIT];
      alu.op = status_pkg::alu_op_e'(
         wdata_q[status_pkg::CMD_OP_LSB +: status_pkg::CMD_OP_W]);
      alu.a = wdata_q[status_pkg::CMD_A_LSB +: status_pkg::DATA_W];
      // with status as destination the file operand is status itself
      alu.b = dest_st ? status_q
            : wdata_q[status_pkg::CMD_B_LSB +: status_pkg::DATA_W];
      alu.cin = status_q[status_pkg::C_BIT];
      status_d = status_q;
      result_d = result_q;
      xl_ofs_d = xl_ofs_q;
      xl_ind_d = xl_ind_q;
      merged = status_q;
      if (do_wr && wsel == status_pkg::SEL_STATUS && wstrb_q[0]) begin
         status_d = (status_q & ~status_pkg::STATUS_WR_MASK) |
                    (wdata_q[status_pkg::DATA_W-1:0] &
                     status_pkg::STATUS_WR_MASK);
      end
      if (do_wr && wsel == status_pkg::SEL_XLATE && wstrb_q[1:0] == 2'h3)
      begin
         xl_ofs_d = wdata_q[status_pkg::DATA_W-1:0];
         xl_ind_d = wdata_q[status_pkg::XL_MODE_BIT];
      end
      if (exec) begin
         result_d = alu.result;
         if (dest_st) begin
            merged = (status_q & ~status_pkg::STATUS_WR_MASK) |
                     (alu.result & status_pkg::STATUS_WR_MASK);
         end
         // the flag update overrides the stored result bit for bit
         if (alu.aff_z) begin
            merged[status_pkg::Z_BIT] = alu.z;
         end
         if (alu.aff_dc) begin
            merged[status_pkg::DC_BIT] = alu.dc;
         end
         if (alu.aff_c) begin
            merged[status_pkg::C_BIT] = alu.c;
         end
         status_d = merged;
      end
      // reset-cause flags move only on core events; expiry wins last
      if (wdt_clear) begin
         status_d[status_pkg::EXPIRY_BIT] = 1'b1;
         status_d[status_pkg::SLEEP_BIT] = 1'b1;
      end
      if (sleep_exec) begin
         status_d[status_pkg::EXPIRY_BIT] = 1'b1;
         status_d[status_pkg::SLEEP_BIT] = 1'b0;
      end
      if (wdt_expired) begin
         status_d[status_pkg::EXPIRY_BIT] = 1'b0;
      end
      // direct: two bank bits over 7 offset bits; indirect: one over 8
      if (xl_ind_q) begin
         bank_addr = {status_q[status_pkg::IND_BANK_BIT], xl_ofs_q};
      end
      else begin
         bank_addr = {
            status_q[status_pkg::DBANK_HI_BIT:status_pkg::DBANK_LO_BIT],
            xl_ofs_q[status_pkg::DIR_OFS_W-1:0]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= status_pkg::STATUS_RST;
         result_q <= 8'h00;
         xl_ofs_q <= 8'h00;
         xl_ind_q <= 1'b0;
      end
      else begin
         status_q <= status_d;
         result_q <= result_d;
         xl_ofs_q <= xl_ofs_d;
         xl_ind_q <= xl_ind_d;
      end
   end

   // one read at a time; arready drops until the data is taken
   always_comb begin
      ar_hs = arvalid && arready_q;
      rsel = status_pkg::reg_decode(araddr);
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (ar_hs) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = status_pkg::RESP_OKAY;
         unique case (rsel)
            status_pkg::SEL_STATUS: rdata_d = {24'h000000, status_q};
            status_pkg::SEL_RESULT: rdata_d = {24'h000000, result_q};
            status_pkg::SEL_XLATE: rdata_d = {23'h000000, bank_addr};
            status_pkg::SEL_CMD: rdata_d = 32'h00000000;
            default: begin
               rdata_d = 32'h00000000;
               rresp_d = status_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= status_pkg::RESP_OKAY;
      end
      else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   mirror_write_a: assert property (
      do_wr && wsel == status_pkg::SEL_STATUS && wstrb_q[0] && !exec
      |=> status_q[7:5] == $past(wdata_q[7:5]))
      else $error("status mirror write lost bank bits");

   sub_borrow_a: assert property (
      alu.op == status_pkg::OP_SUB
      |-> alu.c == (alu.b >= alu.a) &&
          alu.dc == (alu.b[3:0] >= alu.a[3:0]))
      else $error("borrow polarity wrong in subtraction");

   sub_result_a: assert property (
      exec && alu.op == status_pkg::OP_SUB
      |=> result_q == $past(alu.b) - $past(alu.a))
      else $error("subtraction result wrong");

   rotr_carry_a: assert property (
      exec && alu.op == status_pkg::OP_ROR
      |=> status_q[status_pkg::C_BIT] == $past(alu.b[0]))
      else $error("right rotate carry not loaded from bit 0");

   rotl_carry_a: assert property (
      exec && alu.op == status_pkg::OP_ROL
      |=> status_q[status_pkg::C_BIT] == $past(alu.b[7]))
      else $error("left rotate carry not loaded from bit 7");

   reset_state_a: assert property (
      $rose(aresetn) |-> status_q[7:3] == status_pkg::STATUS_RST[7:3])
      else $error("status reset value wrong");

   flag_block_a: assert property (
      exec && dest_st && alu.aff_z
      |=> status_q[status_pkg::Z_BIT] == $past(alu.z))
      else $error("zero flag overwritten by status write");

   cause_readonly_a: assert property (
      !wdt_expired && !sleep_exec && !wdt_clear
      |=> $stable(status_q[status_pkg::EXPIRY_BIT:status_pkg::SLEEP_BIT]))
      else $error("reset-cause flags changed by a write");

   bank_xlate_a: assert property (
      ar_hs && rsel == status_pkg::SEL_XLATE && !xl_ind_q
      |=> rdata_q[8:7] == $past(status_q[6:5]))
      else $error("direct bank translation wrong");

   bresp_hold_a: assert property (
      bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
      else $error("write response dropped before bready");
endmodule : cpu_status_flags

// [verilog/status_alu.sv]
// combinational alu producing a result and the three arithmetic flags
`timescale 1ns/1ns
module status_alu (
   alu_if.alu port // operands in, result and flags out
);
   logic [status_pkg::DATA_W:0] sum;
   logic [status_pkg::NIB_W:0] nib;
   logic [status_pkg::DATA_W-1:0] addend;
   logic is_sub;

   // one shared adder serves add and subtract; a second 5-bit adder gives the nibble carry
   always_comb begin
      is_sub = (port.op == status_pkg::OP_SUB);
      addend = is_sub ? ~port.a : port.a;
      sum = {1'b0, port.b} + {1'b0, addend} + {8'h00, is_sub};
      nib = {1'b0, port.b[status_pkg::NIB_W-1:0]}
          + {1'b0, addend[status_pkg::NIB_W-1:0]} + {4'h0, is_sub};
   end

   // per-operation result and which flags it owns
   always_comb begin
      port.result = port.b;
      port.c = port.cin;
      port.dc = 1'b0;
      port.aff_z = 1'b0;
      port.aff_dc = 1'b0;
      port.aff_c = 1'b0;
      unique case (port.op)
         status_pkg::OP_ADD, status_pkg::OP_SUB: begin
            // carry out of an added complement is the inverted borrow
            port.result = sum[status_pkg::DATA_W-1:0];
            port.c = sum[status_pkg::DATA_W];
            port.dc = nib[status_pkg::NIB_W];
            port.aff_z = 1'b1;
            port.aff_dc = 1'b1;
            port.aff_c = 1'b1;
         end
         status_pkg::OP_AND: begin
            port.result = port.a & port.b;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_IOR: begin
            port.result = port.a | port.b;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_XOR: begin
            port.result = port.a ^ port.b;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_ROR: begin
            port.result = {port.cin, port.b[7:1]};
            port.c = port.b[0];
            port.aff_c = 1'b1;
         end
         status_pkg::OP_ROL: begin
            port.result = {port.b[6:0], port.cin};
            port.c = port.b[7];
            port.aff_c = 1'b1;
         end
         status_pkg::OP_CLR: begin
            port.result = 8'h00;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_MOV: port.result = port.a;
         status_pkg::OP_SWAP: port.result = {port.b[3:0], port.b[7:4]};
         status_pkg::OP_COM: begin
            port.result = ~port.b;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_INC: begin
            port.result = port.b + 8'h01;
            port.aff_z = 1'b1;
         end
         status_pkg::OP_DEC: begin
            port.result = port.b - 8'h01;
            port.aff_z = 1'b1;
         end
         default: port.result = port.b; // unused codes pass f untouched
      endcase
      port.z = (port.result == 8'h00);
   end
endmodule : status_alu
